/* port_pin_function_mux.sv */
module port_pin_function_mux (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_porta_pin,
    input wire logic [7:0] i_portb_pin,
    input wire logic [7:0] i_porta_direction_reg,
    input wire logic [7:0] i_porta_latch,
    input wire logic [7:0] i_porta_analog_select,
    input wire logic [7:0] i_portb_direction_reg,
    input wire logic [7:0] i_portb_latch,
    input wire logic [7:0] i_portb_analog_select,
    input wire logic [7:0] i_porta_pullup_en,
    input wire logic [7:0] i_portb_pullup_en,
    input wire logic [7:0] i_porta_ioc_en,
    input wire logic [7:0] i_portb_ioc_en,
    input wire pin_mux_pkg::mux_ctrl_s i_ctrl,
    input wire logic i_analog_test_sel,
    input wire logic i_sync_clock_out,
    input wire logic i_i2c_scl_drive_low,
    input wire logic i_i2c_sda_drive_low,
    input wire logic i_prog_data_out,
    input wire logic i_prog_data_drive,
    output logic [7:0] o_porta_out,
    output logic [7:0] o_porta_oe_n,
    output logic [7:0] o_portb_out,
    output logic [7:0] o_portb_oe_n,
    output logic [7:0] o_porta_pullup,
    output logic [7:0] o_portb_pullup,
    output logic [7:0] o_porta_read,
    output logic [7:0] o_portb_read,
    output logic [7:0] o_adc_channel_en,
    output logic o_analog_test_active,
    output logic o_analog_test_sel,
    output logic o_sync_clock_in,
    output logic o_sync_clock_on_alt,
    output logic o_sync_clock_active,
    output logic o_timer0_ext_clock_in,
    output logic o_ext_interrupt,
    output logic o_i2c_scl_in,
    output logic o_i2c_sda_in,
    output logic o_serial_prog_data,
    output logic o_serial_prog_clock,
    output logic o_ioc_event
);

    function automatic logic sync_mode(input logic [2:0] mode);
        sync_mode = (mode != pin_mux_pkg::MLTPH_STANDALONE);
    endfunction

    // Open drain: only a low latch on an output pin enables the driver
    function automatic logic od_oe_n(input logic dir, input logic latch);
        od_oe_n = dir | latch;
    endfunction

    logic [7:0] pa_prev_ff;
    logic [7:0] pb_prev_ff;
    logic sync_on;
    logic sync_alt;
    logic [7:0] nxt_pa_out;
    logic [7:0] nxt_pa_oe_n;
    logic [7:0] nxt_pb_out;
    logic [7:0] nxt_pb_oe_n;
    logic [7:0] pa_dir;
    logic [7:0] pb_dir;

    assign sync_on = sync_mode(i_ctrl.multi_phase_field);
    assign sync_alt = sync_on && i_ctrl.alt_clk_sel;

    // Direction 1 means input; analog-selected pins are forced to input too
    assign pa_dir = i_porta_direction_reg | i_porta_analog_select;
    assign pb_dir = i_portb_direction_reg | i_portb_analog_select;

    // Port A drive
    always_comb begin
        nxt_pa_out = 8'h00;
        nxt_pa_oe_n = 8'hff;
        for (int i = 0; i < 4; i++) begin
            nxt_pa_out[i] = i_porta_latch[i];
            nxt_pa_oe_n[i] = pa_dir[i];
        end
        // Open-drain pins only ever pull low
        nxt_pa_out[pin_mux_pkg::PA_OD_PIN_A] = 1'b0;
        nxt_pa_oe_n[pin_mux_pkg::PA_OD_PIN_A] = od_oe_n(pa_dir[4], i_porta_latch[4]);
        nxt_pa_out[pin_mux_pkg::PA_INPUT_ONLY_PIN] = 1'b0;
        nxt_pa_oe_n[pin_mux_pkg::PA_INPUT_ONLY_PIN] = 1'b1;
        nxt_pa_out[pin_mux_pkg::PA_PROG_DATA_PIN] = i_porta_latch[6];
        nxt_pa_oe_n[pin_mux_pkg::PA_PROG_DATA_PIN] = pa_dir[6];
        nxt_pa_out[pin_mux_pkg::PA_SCL_PIN] = 1'b0;
        nxt_pa_oe_n[pin_mux_pkg::PA_SCL_PIN] = od_oe_n(pa_dir[7], i_porta_latch[7]);
        if (i_ctrl.benchmark_enable_bit) begin
            // Buffer is analog; digital driver released so it cannot fight it
            nxt_pa_oe_n[0] = 1'b1;
            nxt_pa_out[0] = 1'b0;
        end
        if (sync_on && !sync_alt) begin
            nxt_pa_out[1] = i_sync_clock_out;
            nxt_pa_oe_n[1] = i_ctrl.multi_phase_field[0] ? 1'b0 : 1'b1;
        end
        if (i_ctrl.prog_mode) begin
            nxt_pa_out[6] = i_prog_data_out;
            nxt_pa_oe_n[6] = !i_prog_data_drive;
            nxt_pa_oe_n[7] = 1'b1;
        end else if (i_ctrl.i2c_enable) begin
            nxt_pa_oe_n[7] = !i_i2c_scl_drive_low;
        end
    end

    // Port B drive
    always_comb begin
        nxt_pb_out = 8'h00;
        nxt_pb_oe_n = 8'hff;
        for (int i = 1; i < 8; i++) begin
            nxt_pb_out[i] = i_portb_latch[i];
            nxt_pb_oe_n[i] = pb_dir[i];
        end
        nxt_pb_oe_n[pin_mux_pkg::PB_SDA_PIN] = od_oe_n(pb_dir[0], i_portb_latch[0]);
        if (i_ctrl.i2c_enable) begin
            nxt_pb_oe_n[pin_mux_pkg::PB_SDA_PIN] = !i_i2c_sda_drive_low;
        end
        if (sync_alt) begin
            nxt_pb_out[5] = i_sync_clock_out;
            nxt_pb_oe_n[5] = i_ctrl.multi_phase_field[0] ? 1'b0 : 1'b1;
        end
    end

    // Port A pad registers
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_porta_out <= 8'h00;
            o_porta_oe_n <= 8'hff;
        end else begin
            o_porta_out <= nxt_pa_out;
            o_porta_oe_n <= nxt_pa_oe_n;
        end
    end

    // Port B pad registers
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_portb_out <= 8'h00;
            o_portb_oe_n <= 8'hff;
        end else begin
            o_portb_out <= nxt_pb_out;
            o_portb_oe_n <= nxt_pb_oe_n;
        end
    end

    // Port A pull-ups: none on A4, A6, A7
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_porta_pullup <= 8'h00;
        end else begin
            o_porta_pullup <= i_porta_pullup_en & pa_dir & 8'h2f;
        end
    end

    // Port B pull-ups: none on open-drain B0
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_portb_pullup <= 8'h00;
        end else begin
            o_portb_pullup <= i_portb_pullup_en & pb_dir & 8'hfe;
        end
    end

    // A/D channel gating
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_adc_channel_en <= 8'h00;
        end else begin
            o_adc_channel_en[3:0] <= i_porta_direction_reg[3:0] & i_porta_analog_select[3:0];
            o_adc_channel_en[6:4] <= 3'h0;
            o_adc_channel_en[7] <= i_portb_direction_reg[5] & i_portb_analog_select[5] & !sync_alt;
        end
    end

    // Analog test status
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_analog_test_active <= 1'b0;
            o_analog_test_sel <= 1'b0;
        end else begin
            o_analog_test_active <= i_ctrl.benchmark_enable_bit;
            o_analog_test_sel <= i_analog_test_sel;
        end
    end

    // Sync clock input and status
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_sync_clock_in <= 1'b0;
            o_sync_clock_on_alt <= 1'b0;
            o_sync_clock_active <= 1'b0;
        end else begin
            o_sync_clock_in <= sync_alt ? i_portb_pin[5] : i_porta_pin[1];
            o_sync_clock_on_alt <= sync_alt;
            o_sync_clock_active <= sync_on;
        end
    end

    // Timer clock and external interrupt
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_timer0_ext_clock_in <= 1'b0;
            o_ext_interrupt <= 1'b0;
        end else begin
            o_timer0_ext_clock_in <= i_ctrl.timer0_clock_select & i_porta_pin[pin_mux_pkg::PA_TIMER_PIN];
            o_ext_interrupt <= i_ctrl.ext_interrupt_enable & i_porta_pin[pin_mux_pkg::PA_TIMER_PIN];
        end
    end

    // Idle-high bus inputs while I2C is off
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_i2c_scl_in <= 1'b1;
            o_i2c_sda_in <= 1'b1;
        end else begin
            o_i2c_scl_in <= i_ctrl.i2c_enable ? i_porta_pin[7] : 1'b1;
            o_i2c_sda_in <= i_ctrl.i2c_enable ? i_portb_pin[0] : 1'b1;
        end
    end

    // Both lines qualified by one mode bit so they always act as a pair
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_serial_prog_data <= 1'b0;
            o_serial_prog_clock <= 1'b0;
        end else begin
            o_serial_prog_data <= i_ctrl.prog_mode & i_porta_pin[6];
            o_serial_prog_clock <= i_ctrl.prog_mode & i_porta_pin[7];
        end
    end

    // Input readback; analog pins read as zero
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_porta_read <= 8'h00;
            o_portb_read <= 8'h00;
        end else begin
            o_porta_read <= i_porta_pin & ~i_porta_analog_select;
            o_portb_read <= i_portb_pin & ~i_portb_analog_select;
        end
    end

    // Change detect; first sample after reset may flag a stale edge
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pa_prev_ff <= 8'h00;
            pb_prev_ff <= 8'h00;
            o_ioc_event <= 1'b0;
        end else begin
            pa_prev_ff <= i_porta_pin;
            pb_prev_ff <= i_portb_pin;
            o_ioc_event <= |(((pa_prev_ff ^ i_porta_pin) & i_porta_ioc_en) |
                ((pb_prev_ff ^ i_portb_pin) & i_portb_ioc_en));
        end
    end

endmodule // port_pin_function_mux

/* pin_mux_pkg.sv */
package pin_mux_pkg;

    // Multi-phase field encodings
    localparam logic [2:0] MLTPH_STANDALONE = 3'h0;
    localparam logic [2:0] MLTPH_MULTI_OUT_MASTER = 3'h1;
    localparam logic [2:0] MLTPH_MULTI_OUT_SLAVE = 3'h2;
    localparam logic [2:0] MLTPH_PHASE_MASTER = 3'h3;
    localparam logic [2:0] MLTPH_PHASE_SLAVE = 3'h4;
    localparam logic [2:0] MLTPH_ALT_PIN_BIT = 3'h4;

    // Pin positions
    localparam int PA_TIMER_PIN = 2;
    localparam int PA_OD_PIN_A = 4;
    localparam int PA_INPUT_ONLY_PIN = 5;
    localparam int PA_PROG_DATA_PIN = 6;
    localparam int PA_SCL_PIN = 7;
    localparam int PB_SDA_PIN = 0;
    localparam int PB_ALT_CLK_PIN = 5;

    // Reset values
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] LAT_RESET = 8'h00;
    localparam logic [7:0] ANSEL_RESET = 8'h0f;

    typedef struct packed {
        logic [7:0] in;
        logic [7:0] out;
        logic [7:0] oe_n;
    } pin_bus_s;

    typedef struct packed {
        logic benchmark_enable_bit;
        logic [2:0] multi_phase_field;
        logic alt_clk_sel;
        logic timer0_clock_select;
        logic ext_interrupt_enable;
        logic i2c_enable;
        logic prog_mode;
    } mux_ctrl_s;

endpackage

/* port_pin_function_mux_monitor.sv */
module port_pin_function_mux_monitor (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_porta_pin,
    input wire logic [7:0] i_porta_direction_reg,
    input wire logic [7:0] i_porta_analog_select,
    input wire pin_mux_pkg::mux_ctrl_s i_ctrl,
    input wire logic [7:0] o_porta_out,
    input wire logic [7:0] o_porta_oe_n,
    input wire logic [7:0] o_portb_out,
    input wire logic [7:0] o_portb_oe_n,
    input wire logic [7:0] o_porta_pullup,
    input wire logic [7:0] o_adc_channel_en,
    input wire logic o_analog_test_active,
    input wire logic o_sync_clock_active,
    input wire logic o_timer0_ext_clock_in,
    input wire logic o_i2c_scl_in
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // Results lag one edge, so the edge after reset is skipped
    sequence s_live;
        !$past(i_srst);
    endsequence
    sequence s_bench;
        s_live ##0 $past(i_ctrl.benchmark_enable_bit);
    endsequence
    a_input_only_pin: assert property (o_porta_oe_n[5]) else $error("A5 driven");
    a_a6_no_pullup: assert property (!o_porta_pullup[6]) else $error("A6 pull-up");
    a_a4_open_drain: assert property (!o_porta_pullup[4] && (o_porta_oe_n[4] || !o_porta_out[4]))
        else $error("A4 not open drain");
    a_a7_open_drain: assert property (!o_porta_pullup[7] && (o_porta_oe_n[7] || !o_porta_out[7]))
        else $error("A7 not open drain");
    a_b0_open_drain: assert property (o_portb_oe_n[0] || !o_portb_out[0]) else $error("B0 high");
    a_adc_route: assert property (s_live |-> o_adc_channel_en[3] == $past(i_porta_direction_reg[3]
        & i_porta_analog_select[3])) else $error("AN3 routing");
    a_test_output: assert property (s_bench |-> o_analog_test_active) else $error("test off");
    a_sync_mode: assert property (s_live |-> o_sync_clock_active == ($past(i_ctrl.multi_phase_field) != 3'h0))
        else $error("sync mode");
    a_timer_clock: assert property (s_live ##0 $past(i_ctrl.timer0_clock_select)
        |-> o_timer0_ext_clock_in == $past(i_porta_pin[2])) else $error("timer clock");
    a_scl_follow: assert property (s_live ##0 $past(i_ctrl.i2c_enable && !i_ctrl.prog_mode)
        |-> o_i2c_scl_in == $past(i_porta_pin[7])) else $error("scl input");
endmodule // port_pin_function_mux_monitor

/* pad_board_model.sv */
module pad_board_model (
    input wire logic i_sys_clk,
    input wire pin_mux_pkg::pin_bus_s i_dev,
    input wire pin_mux_pkg::pin_bus_s i_ext,
    input wire logic [7:0] i_pull,
    output logic [7:0] o_pad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_ff = 8'h00;
    logic [7:0] drive;
    always_ff @(posedge i_sys_clk) begin
        last_ff <= o_pad;
    end
    // Low wins; a released pad without pull-up flips so it never looks held
    assign drive = ~i_dev.oe_n | ~i_ext.oe_n;
    assign o_pad = (drive & (i_dev.oe_n | i_dev.out) & (i_ext.oe_n | i_ext.in)) | (~drive & (i_pull | ~last_ff));
endmodule // pad_board_model

/* port_pin_function_mux_tb.sv */
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module port_pin_function_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0, i_srst = 1'b1;
    logic [7:0] i_porta_direction_reg = 8'hff, i_porta_latch = 8'h00, i_porta_analog_select = 8'h00;
    logic [7:0] i_portb_direction_reg = 8'hff, i_portb_latch = 8'h00, i_portb_analog_select = 8'h00;
    logic [7:0] i_porta_pullup_en = 8'h00, i_portb_pullup_en = 8'h00, i_porta_ioc_en = 8'h00;
    logic [7:0] i_portb_ioc_en = 8'h00, i_porta_pin, i_portb_pin, o_porta_out, o_porta_oe_n, o_portb_out;
    logic [7:0] o_portb_oe_n, o_porta_pullup, o_portb_pullup, o_porta_read, o_portb_read, o_adc_channel_en;
    pin_mux_pkg::mux_ctrl_s i_ctrl = '0;
    pin_mux_pkg::pin_bus_s pa_ext = '0, pb_ext = '0;
    logic i_analog_test_sel = 1'b0, i_sync_clock_out = 1'b0, i_i2c_scl_drive_low = 1'b0;
    logic i_i2c_sda_drive_low = 1'b0, i_prog_data_out = 1'b0, i_prog_data_drive = 1'b0;
    logic o_analog_test_active, o_analog_test_sel, o_sync_clock_in, o_sync_clock_on_alt, o_sync_clock_active;
    logic o_timer0_ext_clock_in, o_ext_interrupt, o_i2c_scl_in, o_i2c_sda_in, o_serial_prog_data;
    logic o_serial_prog_clock, o_ioc_event;
    int failures = 0, samples_checked = 0, n;
    port_pin_function_mux uut (.*);
    pad_board_model pa (.i_sys_clk, .i_dev({8'h00, o_porta_out, o_porta_oe_n}), .i_ext(pa_ext),
        .i_pull(o_porta_pullup), .o_pad(i_porta_pin));
    pad_board_model pb (.i_sys_clk, .i_dev({8'h00, o_portb_out, o_portb_oe_n}), .i_ext(pb_ext),
        .i_pull(o_portb_pullup), .o_pad(i_portb_pin));
    always #2.5 i_sys_clk = ~i_sys_clk;
    task automatic tick(input int k);
        repeat (k) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic count_ioc(output int c);
        c = 0;
        repeat (4) begin
            tick(1);
            c += int'(o_ioc_event === 1'b1);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #4000;
        failures++;
        close_out();
    end
    initial begin
        tick(10);
        `CHK("oe_n", 8'hff, o_porta_oe_n)
        i_srst = 1'b0;
        pa_ext.in = 8'h5a;
        i_porta_analog_select = 8'h0f;
        i_portb_analog_select = 8'h20;
        tick(3);
        `CHK("read", 8'h50, o_porta_read)
        `CHK("adc", 8'h8f, o_adc_channel_en)
        i_porta_direction_reg = 8'hfd;
        i_porta_pullup_en = 8'hff;
        i_portb_pullup_en = 8'hff;
        tick(3);
        `CHK("adc", 8'h8d, o_adc_channel_en)
        `CHK("pullup", 8'h2f, o_porta_pullup & 8'h2f)
        `CHK("pullup", 8'h00, o_porta_pullup & 8'hd0)
        `CHK("sda pullup", 1'b0, o_portb_pullup[0])
        i_porta_analog_select = 8'h00;
        i_portb_analog_select = 8'h00;
        pa_ext.oe_n = 8'hff;
        i_porta_direction_reg = 8'h00;
        i_portb_direction_reg = 8'h00;
        i_porta_latch = 8'hff;
        i_portb_latch = 8'hff;
        tick(3);
        `CHK("oe_n", 8'hb0, o_porta_oe_n)
        `CHK("out", 8'h4f, o_porta_out & ~o_porta_oe_n)
        `CHK("sda oe_n", 1'b1, o_portb_oe_n[0])
        i_porta_latch = 8'h00;
        i_portb_latch = 8'h00;
        tick(3);
        `CHK("oe_n", 8'h20, o_porta_oe_n)
        `CHK("sda oe_n", 1'b0, o_portb_oe_n[0])
        pa_ext.oe_n = 8'h00;
        i_porta_direction_reg = 8'hff;
        i_portb_direction_reg = 8'hff;
        i_ctrl.benchmark_enable_bit = 1'b1;
        i_analog_test_sel = 1'b1;
        tick(3);
        `CHK("test", 1'b1, o_analog_test_active)
        `CHK("test sel", 1'b1, o_analog_test_sel)
        for (int m = 0; m < 5; m++) begin
            i_ctrl = '{1'b0, m[2:0], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
            tick(3);
            `CHK("sync", m != 0, o_sync_clock_active)
        end
        i_ctrl.alt_clk_sel = 1'b1;
        i_portb_analog_select = 8'h20;
        pb_ext.in = 8'h20;
        tick(3);
        `CHK("alt sync in", 1'b1, o_sync_clock_in)
        `CHK("b read", 8'h00, o_portb_read)
        `CHK("alt sync", 1'b1, o_sync_clock_on_alt)
        `CHK("an7", 1'b0, o_adc_channel_en[7])
        i_ctrl = '{1'b0, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        pa_ext.in = 8'h04;
        tick(3);
        `CHK("timer", 1'b1, o_timer0_ext_clock_in)
        `CHK("ext int", 1'b1, o_ext_interrupt)
        i_ctrl = '{1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        pa_ext.in = 8'h80;
        pb_ext.in = 8'h01;
        tick(3);
        `CHK("scl", 1'b1, o_i2c_scl_in)
        `CHK("sda", 1'b1, o_i2c_sda_in)
        i_i2c_scl_drive_low = 1'b1;
        i_i2c_sda_drive_low = 1'b1;
        tick(3);
        `CHK("scl oe_n", 1'b0, o_porta_oe_n[7])
        `CHK("sda oe_n", 1'b0, o_portb_oe_n[0])
        i_i2c_scl_drive_low = 1'b0;
        i_i2c_sda_drive_low = 1'b0;
        i_ctrl = '{1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        pa_ext.in = 8'h40;
        tick(3);
        `CHK("prog data", 1'b1, o_serial_prog_data)
        `CHK("prog clock", 1'b0, o_serial_prog_clock)
        i_ctrl = '0;
        i_porta_ioc_en = 8'hf8;
        tick(3);
        for (int b = 0; b < 8; b++) begin
            pa_ext.in[b] = ~pa_ext.in[b];
            count_ioc(n);
            `CHK("ioc", int'(i_porta_ioc_en[b]), n)
        end
        close_out();
    end
endmodule // port_pin_function_mux_tb
bind port_pin_function_mux port_pin_function_mux_monitor mon (.*);
